// ==== bsms_pkg.sv ====
// bridge sensor mode sequencer: shared constants and state types
// assumes a core clock of 100 MHz driving every timing count
package bsms_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int WIN_UNLOCKED_US = 6000;
  localparam int WIN_LOCKED_US = 1500;
  localparam int WIN_UNLOCKED_CYC = WIN_UNLOCKED_US * CLK_MHZ;
  localparam int WIN_LOCKED_CYC = WIN_LOCKED_US * CLK_MHZ;
  // refresh periods in tenths of ms: [long][fast][code]
  localparam int P_N1_00 = 16;
  localparam int P_N1_01 = 50;
  localparam int P_N1_10 = 250;
  localparam int P_N1_11 = 1250;
  localparam int P_N4_00 = 5;
  localparam int P_N4_01 = 15;
  localparam int P_N4_10 = 65;
  localparam int P_N4_11 = 320;
  localparam int P_L1_00 = 50;
  localparam int P_L1_01 = 85;
  localparam int P_L1_10 = 300;
  localparam int P_L1_11 = 1300;
  localparam int P_L4_00 = 15;
  localparam int P_L4_01 = 25;
  localparam int P_L4_10 = 75;
  localparam int P_L4_11 = 330;
  localparam int CYC_PER_TENTH_MS = 100 * CLK_MHZ;
  // special measurement spacing per refresh code
  localparam logic [7:0] SPC_00 = 8'hFF;
  localparam logic [7:0] SPC_01 = 8'h7F;
  localparam logic [7:0] SPC_10 = 8'h1F;
  localparam logic [7:0] SPC_11 = 8'h0F;
  // config word 01 field positions
  localparam int CFG_RATE_HI = 7;
  localparam int CFG_RATE_LO = 6;
  localparam int CFG_CLK_BIT = 3;
  localparam logic [1:0] RATE_FASTEST = 2'h0;
  // status bits of output packet
  localparam logic [1:0] ST_GOOD = 2'h0;
  localparam logic [1:0] ST_CMD = 2'h1;
  localparam logic [1:0] ST_STALE = 2'h2;
  localparam logic [1:0] ST_DIAG = 2'h3;
  // measurement kinds
  localparam logic [1:0] MEAS_NONE = 2'h0;
  localparam logic [1:0] MEAS_TEMP = 2'h1;
  localparam logic [1:0] MEAS_ZERO = 2'h2;
  localparam logic [1:0] MEAS_BRIDGE = 2'h3;

  typedef enum logic [3:0] {
    S_WINDOW = 4'h0,
    S_CMD = 4'h1,
    S_M_TEMP = 4'h2,
    S_M_ZERO = 4'h3,
    S_M_BRIDGE = 4'h4,
    S_WAIT_CONV = 4'h5,
    S_WAIT_CALC = 4'h6,
    S_GAP = 4'h7,
    S_SLEEP = 4'h8
  } bsms_state_t;

endpackage : bsms_pkg

// ==== bsms_top.sv ====
// bridge sensor mode sequencer: power-on window, command mode, update and sleep scheduling
// assumes the converter and correction engine answer start pulses with done pulses,
// and that i2c/spi framing decodes commands into single-cycle pulses on this clock
// Functional notes
// - after reset the link comes up as an i2c slave.
// - command window lasts 6 ms unlocked, 1.5 ms locked.
// - calibration entry command inside the window enters command mode.
// - command mode talks only over i2c.
// - command mode holds until enter normal command starts normal operation.
// - window expiry selects programmed protocol and, outside sleep mode, runs temp, zero, bridge.
// - first update result ready within 6 ms at 1 MHz locked.
// - sleep mode measures only after a measurement request.
// - fastest refresh code runs measurements back to back.
// - other codes power down after each result write.
// - gap length set by config bits 7:6 and core clock select.
// - normal integration periods 1.6/5/25/125 ms or 0.5/1.5/6.5/32 ms.
// - long integration periods 5/8.5/30/130 ms or 1.5/2.5/7.5/33 ms.
// - special measurement after 255/127/31/15 bridge cycles per code.
// - special measurement is followed at once by a bridge measurement.
// - result written after conversion and correction, and marked valid in the same cycle.
// - fetched result reads stale until a new result lands.
// - in i2c operation the shared pin is a ready output.
// - fetch in every mode, requests in sleep, calibration only over i2c.
// - packet status 00 good, 01 command, 10 stale, 11 fault.
// - config bit 3 picks 4 MHz core or divided 1 MHz.
// - read request runs temp, zero, bridge; write request bridge only.
module bsms_top #(
  parameter int WIN_UNLOCKED = bsms_pkg::WIN_UNLOCKED_CYC,
  parameter int WIN_LOCKED = bsms_pkg::WIN_LOCKED_CYC,
  parameter int TENTH_MS = bsms_pkg::CYC_PER_TENTH_MS,
  parameter int CNT_W = 28
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_CFG_WORD01,
  input wire logic I_CFG_SPI_SEL,
  input wire logic I_CFG_SLEEP_MODE,
  input wire logic I_CFG_LONG_INT,
  input wire logic I_CFG_LOCKED,
  input wire logic I_DIAG_FAULT,
  input wire logic I_ENTER_CAL_CMD,
  input wire logic I_ENTER_NORMAL_CMD,
  input wire logic I_CAL_CMD,
  input wire logic I_CMD_VIA_SPI,
  input wire logic I_READ_MEASURE_REQUEST,
  input wire logic I_WRITE_MEASURE_REQUEST,
  input wire logic I_RESULT_FETCH,
  input wire logic I_CONV_DONE,
  input wire logic I_CALC_DONE,
  output logic O_USE_SPI,
  output logic O_CMD_MODE,
  output logic O_CAL_EXEC,
  output logic O_CONV_START,
  output logic [1:0] O_CONV_KIND,
  output logic O_CALC_START,
  output logic O_RESULT_WRITE,
  output logic [1:0] O_STATUS,
  output logic O_READY,
  output logic O_POWER_DOWN,
  output logic O_FAST_CLK
);

  // ----------------------------------------
  // state record
  // ----------------------------------------
  typedef struct packed {
    bsms_pkg::bsms_state_t st;
    logic armed;
    logic [CNT_W-1:0] tmr;
    logic [7:0] spc_cnt;
    logic next_zero;
    logic special_pend;
    logic first_seq;
    logic bridge_only;
    logic valid;
    logic have_data;
    logic use_spi;
    logic cmd_mode;
    logic cal_exec;
    logic conv_start;
    logic [1:0] conv_kind;
    logic calc_start;
    logic result_write;
    logic ready;
    logic power_down;
    logic fast_clk;
    logic [1:0] status;
  } bsms_reg_t;

  bsms_reg_t r_q;
  bsms_reg_t r_d;

  logic [1:0] rate;
  logic fast;
  logic [CNT_W-1:0] gap_cyc;
  logic [7:0] spc_reload;
  logic [31:0] tenths;

  assign rate = I_CFG_WORD01[bsms_pkg::CFG_RATE_HI:bsms_pkg::CFG_RATE_LO];
  assign fast = I_CFG_WORD01[bsms_pkg::CFG_CLK_BIT];

  // ----------------------------------------
  // refresh period lookup
  // ----------------------------------------
  always_comb begin
    tenths = 32'(bsms_pkg::P_N1_00);
    case ({I_CFG_LONG_INT, fast, rate})
      4'h0: tenths = 32'(bsms_pkg::P_N1_00);
      4'h1: tenths = 32'(bsms_pkg::P_N1_01);
      4'h2: tenths = 32'(bsms_pkg::P_N1_10);
      4'h3: tenths = 32'(bsms_pkg::P_N1_11);
      4'h4: tenths = 32'(bsms_pkg::P_N4_00);
      4'h5: tenths = 32'(bsms_pkg::P_N4_01);
      4'h6: tenths = 32'(bsms_pkg::P_N4_10);
      4'h7: tenths = 32'(bsms_pkg::P_N4_11);
      4'h8: tenths = 32'(bsms_pkg::P_L1_00);
      4'h9: tenths = 32'(bsms_pkg::P_L1_01);
      4'hA: tenths = 32'(bsms_pkg::P_L1_10);
      4'hB: tenths = 32'(bsms_pkg::P_L1_11);
      4'hC: tenths = 32'(bsms_pkg::P_L4_00);
      4'hD: tenths = 32'(bsms_pkg::P_L4_01);
      4'hE: tenths = 32'(bsms_pkg::P_L4_10);
      default: tenths = 32'(bsms_pkg::P_L4_11);
    endcase
    // period counted from the bridge start; conversion time eats into it
    gap_cyc = CNT_W'(tenths * 32'(TENTH_MS));
    case (rate)
      2'h0: spc_reload = bsms_pkg::SPC_00;
      2'h1: spc_reload = bsms_pkg::SPC_01;
      2'h2: spc_reload = bsms_pkg::SPC_10;
      default: spc_reload = bsms_pkg::SPC_11;
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.conv_start = 1'b0;
    r_d.calc_start = 1'b0;
    r_d.result_write = 1'b0;
    r_d.cal_exec = 1'b0;
    r_d.ready = 1'b0;
    r_d.fast_clk = fast;
    if (r_q.tmr != '0) begin
      r_d.tmr = r_q.tmr - CNT_W'(1);
    end

    case (r_q.st)
      bsms_pkg::S_WINDOW: begin
        r_d.use_spi = 1'b0;
        r_d.power_down = 1'b0;
        if (!r_q.armed) begin
          // first edge after release: lock strap sampled here, zeroing slot first
          r_d.armed = 1'b1;
          r_d.next_zero = 1'b1;
          r_d.tmr = I_CFG_LOCKED ? CNT_W'(WIN_LOCKED) : CNT_W'(WIN_UNLOCKED);
        end else if (I_ENTER_CAL_CMD && !I_CMD_VIA_SPI) begin
          r_d.st = bsms_pkg::S_CMD;
          r_d.cmd_mode = 1'b1;
        end else if (r_q.tmr == '0) begin
          r_d.use_spi = I_CFG_SPI_SEL;
          r_d.first_seq = 1'b1;
          r_d.st = I_CFG_SLEEP_MODE ? bsms_pkg::S_SLEEP : bsms_pkg::S_M_TEMP;
          r_d.power_down = I_CFG_SLEEP_MODE;
        end
      end
      bsms_pkg::S_CMD: begin
        r_d.use_spi = 1'b0;
        r_d.cal_exec = I_CAL_CMD && !I_CMD_VIA_SPI;
        if (I_ENTER_NORMAL_CMD && !I_CMD_VIA_SPI) begin
          r_d.cmd_mode = 1'b0;
          r_d.use_spi = I_CFG_SPI_SEL;
          r_d.first_seq = 1'b1;
          r_d.st = I_CFG_SLEEP_MODE ? bsms_pkg::S_SLEEP : bsms_pkg::S_M_TEMP;
          r_d.power_down = I_CFG_SLEEP_MODE;
        end
      end
      bsms_pkg::S_M_TEMP: begin
        r_d.conv_start = 1'b1;
        r_d.conv_kind = bsms_pkg::MEAS_TEMP;
        r_d.st = bsms_pkg::S_WAIT_CONV;
      end
      bsms_pkg::S_M_ZERO: begin
        r_d.conv_start = 1'b1;
        r_d.conv_kind = bsms_pkg::MEAS_ZERO;
        r_d.st = bsms_pkg::S_WAIT_CONV;
      end
      bsms_pkg::S_M_BRIDGE: begin
        r_d.conv_start = 1'b1;
        r_d.conv_kind = bsms_pkg::MEAS_BRIDGE;
        r_d.tmr = gap_cyc;
        r_d.st = bsms_pkg::S_WAIT_CONV;
      end
      bsms_pkg::S_WAIT_CONV: begin
        if (I_CONV_DONE) begin
          case (r_q.conv_kind)
            bsms_pkg::MEAS_TEMP: r_d.st = bsms_pkg::S_M_ZERO;
            bsms_pkg::MEAS_ZERO: r_d.st = bsms_pkg::S_M_BRIDGE;
            bsms_pkg::MEAS_BRIDGE: begin
              r_d.calc_start = 1'b1;
              r_d.st = bsms_pkg::S_WAIT_CALC;
            end
            default: r_d.st = bsms_pkg::S_M_BRIDGE;
          endcase
        end
      end
      bsms_pkg::S_WAIT_CALC: begin
        if (I_CALC_DONE) begin
          r_d.result_write = 1'b1;
          r_d.valid = 1'b1;
          r_d.have_data = 1'b1;
          r_d.ready = !r_q.use_spi;
          r_d.first_seq = 1'b0;
          if (r_q.first_seq) begin
            r_d.spc_cnt = spc_reload;
          end else if (r_q.spc_cnt != 8'h00) begin
            r_d.spc_cnt = r_q.spc_cnt - 8'h01;
          end
          if (I_CFG_SLEEP_MODE) begin
            r_d.st = bsms_pkg::S_SLEEP;
            r_d.power_down = 1'b1;
          end else begin
            r_d.st = bsms_pkg::S_GAP;
            r_d.power_down = (rate != bsms_pkg::RATE_FASTEST);
          end
        end
      end
      bsms_pkg::S_GAP: begin
        if (rate == bsms_pkg::RATE_FASTEST || r_q.tmr == '0) begin
          r_d.power_down = 1'b0;
          if (r_q.spc_cnt == 8'h00) begin
            r_d.spc_cnt = spc_reload;
            r_d.next_zero = !r_q.next_zero;
            // special first, bridge right after it
            r_d.st = r_q.next_zero ? bsms_pkg::S_M_ZERO : bsms_pkg::S_M_TEMP;
            r_d.special_pend = 1'b1;
          end else begin
            r_d.st = bsms_pkg::S_M_BRIDGE;
          end
        end
      end
      bsms_pkg::S_SLEEP: begin
        if (I_READ_MEASURE_REQUEST) begin
          r_d.power_down = 1'b0;
          r_d.st = bsms_pkg::S_M_TEMP;
        end else if (I_WRITE_MEASURE_REQUEST && !I_CMD_VIA_SPI) begin
          r_d.power_down = 1'b0;
          r_d.st = bsms_pkg::S_M_BRIDGE;
        end
      end
      default: r_d.st = bsms_pkg::S_WINDOW;
    endcase

    // a special temp or zero slot chains straight to bridge
    if (r_q.st == bsms_pkg::S_WAIT_CONV && I_CONV_DONE && r_q.special_pend &&
        r_q.conv_kind != bsms_pkg::MEAS_BRIDGE) begin
      r_d.st = bsms_pkg::S_M_BRIDGE;
      r_d.special_pend = 1'b0;
    end

    // fetch clears valid; a same-cycle new write wins
    if (I_RESULT_FETCH && !(r_q.st == bsms_pkg::S_WAIT_CALC && I_CALC_DONE)) begin
      r_d.valid = 1'b0;
    end

    if (r_d.cmd_mode) begin
      r_d.status = bsms_pkg::ST_CMD;
    end else if (I_DIAG_FAULT) begin
      r_d.status = bsms_pkg::ST_DIAG;
    end else if (r_d.valid) begin
      r_d.status = bsms_pkg::ST_GOOD;
    end else begin
      r_d.status = bsms_pkg::ST_STALE;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      r_q <= '0;
      r_q.st <= bsms_pkg::S_WINDOW;
      r_q.status <= bsms_pkg::ST_STALE;
    end else begin
      r_q <= r_d;
    end
  end

  assign O_USE_SPI = r_q.use_spi;
  assign O_CMD_MODE = r_q.cmd_mode;
  assign O_CAL_EXEC = r_q.cal_exec;
  assign O_CONV_START = r_q.conv_start;
  assign O_CONV_KIND = r_q.conv_kind;
  assign O_CALC_START = r_q.calc_start;
  assign O_RESULT_WRITE = r_q.result_write;
  assign O_STATUS = r_q.status;
  assign O_READY = r_q.ready;
  assign O_POWER_DOWN = r_q.power_down;
  assign O_FAST_CLK = r_q.fast_clk;

endmodule : bsms_top

// ==== bsms_properties.sv ====
// port relations of the mode sequencer, bound into bsms_top
// assumes one core clock domain and a synchronous active-high reset
module bsms_properties (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_CFG_WORD01,
  input wire logic I_ENTER_CAL_CMD,
  input wire logic I_ENTER_NORMAL_CMD,
  input wire logic I_RESULT_FETCH,
  input wire logic I_CONV_DONE,
  input wire logic I_CALC_DONE,
  input wire logic I_DIAG_FAULT,
  input wire logic O_USE_SPI,
  input wire logic O_CMD_MODE,
  input wire logic [1:0] O_CONV_KIND,
  input wire logic O_CALC_START,
  input wire logic O_RESULT_WRITE,
  input wire logic [1:0] O_STATUS,
  input wire logic O_READY,
  input wire logic O_POWER_DOWN,
  input wire logic O_FAST_CLK
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  property p_ready_i2c; O_READY |-> O_RESULT_WRITE && !O_USE_SPI; endproperty
  a_ready_i2c: assert property (p_ready_i2c) else $error("ready pulse wrong");
  property p_cmd_entry; $rose(O_CMD_MODE) |-> $past(I_ENTER_CAL_CMD); endproperty
  a_cmd_entry: assert property (p_cmd_entry) else $error("command mode without entry");
  property p_cmd_i2c; O_CMD_MODE |-> !O_USE_SPI; endproperty
  a_cmd_i2c: assert property (p_cmd_i2c) else $error("spi used in command mode");
  property p_cmd_hold; O_CMD_MODE && !I_ENTER_NORMAL_CMD |=> O_CMD_MODE; endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command mode left early");
  property p_write_calc; O_RESULT_WRITE |-> $past(I_CALC_DONE) && O_STATUS == 2'h0; endproperty
  a_write_calc: assert property (p_write_calc) else $error("write not after calc");
  property p_calc_bridge; O_CALC_START |-> $past(I_CONV_DONE) && O_CONV_KIND == 2'h3; endproperty
  a_calc_bridge: assert property (p_calc_bridge) else $error("calc not after bridge");
  property p_stale;
    I_RESULT_FETCH && !O_CMD_MODE && !I_CALC_DONE && !I_DIAG_FAULT |=>
      O_STATUS == bsms_pkg::ST_STALE;
  endproperty
  a_stale: assert property (p_stale) else $error("fetch did not mark stale");
  property p_diag;
    I_DIAG_FAULT && !O_CMD_MODE && !I_ENTER_CAL_CMD |=> O_STATUS == bsms_pkg::ST_DIAG;
  endproperty
  a_diag: assert property (p_diag) else $error("fault not reported");
  property p_pd_rate; O_POWER_DOWN |-> I_CFG_WORD01[7:6] != 2'h0; endproperty
  a_pd_rate: assert property (p_pd_rate) else $error("power down at fastest rate");
  property p_fast_clk; !I_RST |=> O_FAST_CLK == $past(I_CFG_WORD01[3]); endproperty
  a_fast_clk: assert property (p_fast_clk) else $error("clock select not reported");
endmodule : bsms_properties

// ==== bsms_conv_model.sv ====
// converter and correction engine answering start pulses with done pulses
// assumes start pulses come one at a time from the sequencer
module bsms_conv_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic conv_start,
  input wire logic calc_start,
  input wire logic slow,
  output logic conv_done,
  output logic calc_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cc;
  int kc;
  // done never comes without a start, a slow engine shows the waiting states
  always_ff @(posedge clk) begin
    conv_done <= 1'b0;
    calc_done <= 1'b0;
    if (rst) begin
      cc <= 0;
      kc <= 0;
    end else begin
      if (conv_start) cc <= slow ? 12 : 3;
      else if (cc > 1) cc <= cc - 1;
      else if (cc == 1) begin
        cc <= 0;
        conv_done <= 1'b1;
      end
      if (calc_start) kc <= slow ? 9 : 2;
      else if (kc > 1) kc <= kc - 1;
      else if (kc == 1) begin
        kc <= 0;
        calc_done <= 1'b1;
      end
    end
  end
endmodule : bsms_conv_model

// ==== testbench.sv ====
// self-checking bench of the mode sequencer with a converter model
// assumes shortened window and period counts set below
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIN_U = 600;
  localparam int WIN_L = 150;
  localparam int TMS = 10;
  logic clk, rst, spi_sel, sleep, locked, ecal, enorm, cal, via_spi, rmr, wmr, fetch, slow;
  logic diag, lng;
  logic [7:0] cfg;
  logic use_spi, cmd_mode, cal_exec, conv_start, calc_start, res_wr, ready, pdown, fast_clk;
  logic conv_done, calc_done;
  logic [1:0] kind, status;
  int n_errors, tests_run, cyc, n_conv, t_start;
  bsms_top #(.WIN_UNLOCKED(WIN_U), .WIN_LOCKED(WIN_L), .TENTH_MS(TMS)) uut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_CFG_WORD01(cfg), .I_CFG_SPI_SEL(spi_sel),
    .I_CFG_SLEEP_MODE(sleep), .I_CFG_LONG_INT(lng), .I_CFG_LOCKED(locked), .I_DIAG_FAULT(diag),
    .I_ENTER_CAL_CMD(ecal), .I_ENTER_NORMAL_CMD(enorm), .I_CAL_CMD(cal), .I_CMD_VIA_SPI(via_spi),
    .I_READ_MEASURE_REQUEST(rmr), .I_WRITE_MEASURE_REQUEST(wmr), .I_RESULT_FETCH(fetch),
    .I_CONV_DONE(conv_done), .I_CALC_DONE(calc_done), .O_USE_SPI(use_spi), .O_CMD_MODE(cmd_mode),
    .O_CAL_EXEC(cal_exec), .O_CONV_START(conv_start), .O_CONV_KIND(kind),
    .O_CALC_START(calc_start), .O_RESULT_WRITE(res_wr), .O_STATUS(status), .O_READY(ready),
    .O_POWER_DOWN(pdown), .O_FAST_CLK(fast_clk));
  bsms_conv_model u_conv (.clk(clk), .rst(rst), .conv_start(conv_start),
    .calc_start(calc_start), .slow(slow), .conv_done(conv_done), .calc_done(calc_done));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= rst ? 0 : cyc + 1;
    n_conv <= rst ? 0 : n_conv + int'(conv_start === 1'b1);
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task conclude;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task start(input logic [7:0] c, input logic lk, input logic sp, input logic sl);
    {ecal, enorm, cal, via_spi, rmr, wmr, fetch} = '0;
    cfg = c;
    locked = lk;
    spi_sel = sp;
    sleep = sl;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
  endtask : start
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task meas(input logic [1:0] k);
    int n;
    n = 0;
    while (conv_start !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check({conv_start, kind}, {1'b1, k}, "conversion kind");
    t_start = cyc;
    @(negedge clk);
  endtask : meas
  task result(input logic pd, input logic rdy);
    int n;
    n = 0;
    while (res_wr !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check({res_wr, ready, status, pdown}, {1'b1, rdy, 2'h0, pd}, "result write");
    @(negedge clk);
  endtask : result
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_update;
    int n, t0;
    start(8'h40, 1'b1, 1'b0, 1'b0);
    n = 0;
    while (conv_start !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check(n >= WIN_L && n <= WIN_L + 4, 1'b1, "locked window length");
    meas(bsms_pkg::MEAS_TEMP);
    meas(bsms_pkg::MEAS_ZERO);
    meas(bsms_pkg::MEAS_BRIDGE);
    t0 = t_start;
    result(1'b1, 1'b1);
    check(cyc <= 60 * TMS, 1'b1, "first result late");
    pulse(fetch);
    check(status, bsms_pkg::ST_STALE, "stale after fetch");
    meas(bsms_pkg::MEAS_BRIDGE);
    check(t_start - t0 >= 50 * TMS - 2 && t_start - t0 <= 50 * TMS + 2, 1'b1, "period");
    $display("update test done");
  endtask : t_update
  task t_command;
    start(8'h48, 1'b0, 1'b1, 1'b0);
    repeat (WIN_L + 20) @(negedge clk);
    check({fast_clk, use_spi, n_conv[29:0]}, {1'b1, 1'b0, 30'h0}, "window still open");
    pulse(ecal);
    check({cmd_mode, use_spi, status}, {1'b1, 1'b0, bsms_pkg::ST_CMD}, "command mode");
    pulse(cal);
    check(cal_exec, 1'b1, "calibration executed");
    via_spi = 1'b1;
    pulse(cal);
    via_spi = 1'b0;
    check(cal_exec, 1'b0, "spi calibration refused");
    repeat (WIN_U) @(negedge clk);
    check({cmd_mode, n_conv[30:0]}, {1'b1, 31'h0}, "command mode kept");
    pulse(enorm);
    meas(bsms_pkg::MEAS_TEMP);
    check(use_spi, 1'b1, "programmed protocol");
    meas(bsms_pkg::MEAS_ZERO);
    meas(bsms_pkg::MEAS_BRIDGE);
    result(1'b1, 1'b0);
    $display("command test done");
  endtask : t_command
  task t_sleep;
    start(8'h40, 1'b1, 1'b0, 1'b1);
    repeat (WIN_L + 300) @(negedge clk);
    via_spi = 1'b1;
    pulse(wmr);
    via_spi = 1'b0;
    repeat (20) @(negedge clk);
    check(n_conv, 32'h0, "no measurement unasked");
    pulse(wmr);
    meas(bsms_pkg::MEAS_BRIDGE);
    result(1'b1, 1'b1);
    pulse(fetch);
    check(status, bsms_pkg::ST_STALE, "stale after fetch");
    pulse(rmr);
    meas(bsms_pkg::MEAS_TEMP);
    meas(bsms_pkg::MEAS_ZERO);
    meas(bsms_pkg::MEAS_BRIDGE);
    result(1'b1, 1'b1);
    diag = 1'b1;
    @(negedge clk);
    check(status, bsms_pkg::ST_DIAG, "fault status");
    diag = 1'b0;
    $display("sleep test done");
  endtask : t_sleep
  task t_long;
    int t0;
    lng = 1'b1;
    start(8'h40, 1'b1, 1'b0, 1'b0);
    meas(bsms_pkg::MEAS_TEMP);
    meas(bsms_pkg::MEAS_ZERO);
    meas(bsms_pkg::MEAS_BRIDGE);
    t0 = t_start;
    result(1'b1, 1'b1);
    meas(bsms_pkg::MEAS_BRIDGE);
    t0 = t_start - t0;
    check(t0 >= 85 * TMS - 2 && t0 <= 85 * TMS + 2, 1'b1, "long period");
    lng = 1'b0;
    $display("long integration test done");
  endtask : t_long
  task t_fastest;
    int nb;
    slow = 1'b0;
    start(8'h00, 1'b1, 1'b0, 1'b0);
    meas(bsms_pkg::MEAS_TEMP);
    meas(bsms_pkg::MEAS_ZERO);
    meas(bsms_pkg::MEAS_BRIDGE);
    result(1'b0, 1'b1);
    nb = 0;
    // second round covers the temperature slot and its chain to the bridge
    for (int r = 0; r < 2; r++) begin
      while (nb < 300) begin
        while (conv_start !== 1'b1) @(negedge clk);
        if (kind !== bsms_pkg::MEAS_BRIDGE) break;
        nb++;
        @(negedge clk);
      end
      check(nb, 255, "bridge cycles between specials");
      check(kind, r == 0 ? bsms_pkg::MEAS_ZERO : bsms_pkg::MEAS_TEMP, "special slot");
      @(negedge clk);
      meas(bsms_pkg::MEAS_BRIDGE);
      nb = 1;
    end
    $display("fastest test done");
  endtask : t_fastest
  initial begin
    n_errors = 0;
    tests_run = 0;
    slow = 1'b1;
    diag = 1'b0;
    lng = 1'b0;
    start(8'h40, 1'b1, 1'b0, 1'b0);
    t_update();
    t_command();
    t_sleep();
    t_long();
    t_fastest();
    conclude();
  end
  initial begin
    #500_000;
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end
endmodule : testbench
bind bsms_top bsms_properties u_props (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST),
  .I_CFG_WORD01(I_CFG_WORD01), .I_ENTER_CAL_CMD(I_ENTER_CAL_CMD),
  .I_ENTER_NORMAL_CMD(I_ENTER_NORMAL_CMD), .I_RESULT_FETCH(I_RESULT_FETCH),
  .I_CONV_DONE(I_CONV_DONE), .I_CALC_DONE(I_CALC_DONE), .I_DIAG_FAULT(I_DIAG_FAULT),
  .O_USE_SPI(O_USE_SPI),
  .O_CMD_MODE(O_CMD_MODE), .O_CONV_KIND(O_CONV_KIND), .O_CALC_START(O_CALC_START),
  .O_RESULT_WRITE(O_RESULT_WRITE), .O_STATUS(O_STATUS), .O_READY(O_READY),
  .O_POWER_DOWN(O_POWER_DOWN), .O_FAST_CLK(O_FAST_CLK));
